//--- core/sats_core.sv
// Serial access status tracker: target bus observer, registers, status word
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
module sats_core import sats_pkg::*; #(
   parameter logic [6:0] OWN_ADDR_RST = RST_OWN_ADDR
) (
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   input  wire logic              i_soft_rst,
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   output logic                   o_sda_out,
   output logic                   o_sda_oe,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   input  wire logic [7:0]        i_tgt_rd_byte,
   output logic      [7:0]        o_tgt_wr_byte,
   output logic                   o_tgt_wr_valid,
   input  wire logic              i_init_stage_valid,
   input  wire logic [2:0]        i_init_stage,
   input  wire logic              i_init_ack_slot,
   input  wire logic              i_init_byte_done,
   input  wire logic              i_init_done,
   input  wire logic              i_init_abort,
   output logic                   o_init_start,
   output logic      [3:0]        o_init_size
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0]   pins;
   logic         scl;
   logic         sda;
   logic         scl_q_reg;
   logic         sda_q_reg;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_det;
   logic         stop_det;
   logic         line_busy_reg;
   sats_tstate_t state_reg;
   sats_tstage_t tstage_reg;
   logic         selected_reg;
   logic         read_dir_reg;
   logic [3:0]   bit_cnt_reg;
   logic [7:0]   shift_reg;
   logic [7:0]   tx_reg;
   logic         master_nack_reg;
   logic [7:0]   sub_addr_reg;
   logic         sda_oe_reg;
   logic [7:0]   wr_byte_reg;
   logic         wr_valid_reg;
   logic         in_frame;
   logic         byte_in;
   logic         ack_end;
   logic         addr_hit;
   logic         tgt_ack;
   logic         hold_off;
   logic         we_ack;
   logic         next_read;
   logic         tgt_en_reg;
   logic [6:0]   own_addr_reg;
   logic         start_reg;
   logic [3:0]   size_reg;
   logic [31:0]  status_word;
   logic [31:0]  rdata_reg;
   logic         wr_cfg;
   logic         wr_ctrl;

   sats_init_if init_bus ();

   // ----------------------------------------------------------------
   // Pin synchronisation and bus condition detection
   // ----------------------------------------------------------------
   sats_pin_sync #(
      .WIDTH      (2),
      .IDLE_LEVEL (2'h3)
   ) u_pin_sync (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_async ({i_scl, i_sda}),
      .o_level (pins)
   );

   assign scl = pins[1];
   assign sda = pins[0];

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl;
         sda_q_reg <= sda;
      end
   end

   assign scl_rise  = scl & ~scl_q_reg;
   assign scl_fall  = ~scl & scl_q_reg;
   assign start_det = scl & scl_q_reg & sda_q_reg & ~sda;
   assign stop_det  = scl & scl_q_reg & ~sda_q_reg & sda;

   // Not set again after soft reset until a fresh START is seen
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         line_busy_reg <= 1'b0;
      end else if (i_soft_rst) begin
         line_busy_reg <= 1'b0;
      end else if (start_det) begin
         line_busy_reg <= 1'b1;
      end else if (stop_det) begin
         line_busy_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Bit counter and shifters
   // ----------------------------------------------------------------
   assign in_frame = (state_reg != TS_IDLE);
   assign byte_in  = in_frame & scl_fall & (bit_cnt_reg == LAST_DATA_BIT);
   assign ack_end  = in_frame & scl_fall & (bit_cnt_reg == ACK_BIT);
   assign addr_hit = tgt_en_reg &
                     ((shift_reg[7:1] == own_addr_reg) | (shift_reg[7:1] == ALERT_ADDR));

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_cnt_reg <= 4'h0;
      end else if (i_soft_rst) begin
         bit_cnt_reg <= 4'h0;
      end else if (start_det) begin
         // All ones, so the START's own clock fall wraps the count to bit 0
         bit_cnt_reg <= 4'hf;
      end else if (in_frame && scl_fall) begin
         bit_cnt_reg <= (bit_cnt_reg == ACK_BIT) ? 4'h0 : bit_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_reg       <= 8'h00;
         master_nack_reg <= 1'b0;
      end else if (in_frame && scl_rise) begin
         if (bit_cnt_reg < ACK_BIT) begin
            shift_reg <= {shift_reg[6:0], sda};
         end else begin
            master_nack_reg <= sda;
         end
      end
   end

   // ----------------------------------------------------------------
   // Target sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg    <= TS_IDLE;
         selected_reg <= 1'b0;
         read_dir_reg <= 1'b0;
      end else if (i_soft_rst) begin
         state_reg    <= TS_IDLE;
         selected_reg <= 1'b0;
      end else if (start_det) begin
         state_reg    <= TS_ADDR;
         selected_reg <= 1'b0;
      end else if (stop_det) begin
         state_reg    <= TS_IDLE;
         selected_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            TS_ADDR: begin
               if (byte_in && addr_hit) begin
                  selected_reg <= 1'b1;
                  read_dir_reg <= shift_reg[0];
               end else if (byte_in) begin
                  state_reg <= TS_WAIT;
               end else if (ack_end && selected_reg) begin
                  state_reg <= read_dir_reg ? TS_RDATA : TS_SUB;
               end
            end
            TS_SUB: begin
               if (ack_end) begin
                  state_reg <= TS_WDATA;
               end
            end
            TS_RDATA: begin
               // A master NACK ends the read; wait for STOP or repeated START
               if (ack_end && master_nack_reg) begin
                  state_reg    <= TS_WAIT;
                  selected_reg <= 1'b0;
               end
            end
            TS_WDATA, TS_WAIT, TS_IDLE: begin
               state_reg <= state_reg;
            end
            default: begin
               state_reg <= TS_IDLE;
            end
         endcase
      end
   end

   // Stage only moves forward inside a frame; STOP and abort leave it as is
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tstage_reg <= TSTG_ADDR;
      end else if (i_soft_rst) begin
         tstage_reg <= TSTG_ADDR;
      end else if (start_det) begin
         tstage_reg <= TSTG_ADDR;
      end else if (ack_end && state_reg == TS_ADDR && selected_reg) begin
         tstage_reg <= read_dir_reg ? TSTG_RDATA : TSTG_SUB;
      end else if (ack_end && state_reg == TS_SUB) begin
         tstage_reg <= TSTG_WDATA;
      end
   end

   assign next_read = ack_end & ((state_reg == TS_ADDR && selected_reg && read_dir_reg) |
                                 (state_reg == TS_RDATA && !master_nack_reg));

   // ----------------------------------------------------------------
   // Sub-address and data transfer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sub_addr_reg <= 8'h00;
      end else if (ack_end && state_reg == TS_SUB) begin
         sub_addr_reg <= shift_reg;
      end else if (ack_end && state_reg == TS_WDATA) begin
         sub_addr_reg <= sub_addr_reg + 8'h01;
      end else if (ack_end && state_reg == TS_RDATA && !master_nack_reg) begin
         sub_addr_reg <= sub_addr_reg + 8'h01;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_reg <= 8'hff;
      end else if (next_read) begin
         tx_reg <= i_tgt_rd_byte;
      end else if (state_reg == TS_RDATA && scl_fall && bit_cnt_reg < LAST_DATA_BIT) begin
         tx_reg <= {tx_reg[6:0], 1'b1};
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_byte_reg  <= 8'h00;
         wr_valid_reg <= 1'b0;
      end else begin
         wr_valid_reg <= ack_end & (state_reg == TS_WDATA);
         if (ack_end && state_reg == TS_WDATA) begin
            wr_byte_reg <= shift_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Data line drive
   // ----------------------------------------------------------------
   assign we_ack = (bit_cnt_reg == ACK_BIT) &
                   ((state_reg == TS_ADDR && selected_reg) |
                    state_reg == TS_SUB | state_reg == TS_WDATA);

   // Registered drive lags synchronised SCL low by two cycles, well inside the hold time
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sda_oe_reg <= 1'b0;
      end else if (i_soft_rst) begin
         sda_oe_reg <= 1'b0;
      end else begin
         sda_oe_reg <= we_ack |
                       (state_reg == TS_RDATA && bit_cnt_reg < ACK_BIT && !tx_reg[7]);
      end
   end

   assign tgt_ack  = (state_reg == TS_ADDR || state_reg == TS_SUB ||
                      state_reg == TS_WDATA || state_reg == TS_RDATA) &&
                     (bit_cnt_reg == ACK_BIT);
   assign hold_off = line_busy_reg & ~selected_reg & (state_reg != TS_ADDR);

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   assign wr_cfg  = i_wr & (i_addr == OFF_TARGET_CFG);
   assign wr_ctrl = i_wr & (i_addr == OFF_INIT_CTRL);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tgt_en_reg   <= RST_TGT_EN;
         own_addr_reg <= OWN_ADDR_RST;
      end else if (wr_cfg) begin
         tgt_en_reg   <= i_wdata[POS_CFG_EN];
         own_addr_reg <= i_wdata[POS_CFG_ADDR +: 7];
      end
   end

   // Software set wins over a completion arriving in the same cycle
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_reg <= 1'b0;
      end else if (i_soft_rst) begin
         start_reg <= 1'b0;
      end else if (wr_ctrl && i_wdata[POS_CTRL_START]) begin
         start_reg <= 1'b1;
      end else if (i_init_done || i_init_abort) begin
         start_reg <= 1'b0;
      end
   end

   // Size is frozen while an operation runs
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         size_reg <= RST_SIZE;
      end else if (wr_ctrl && !start_reg) begin
         size_reg <= i_wdata[POS_CTRL_SIZE +: 4];
      end
   end

   // ----------------------------------------------------------------
   // Initiator tracking
   // ----------------------------------------------------------------
   assign init_bus.busy        = start_reg;
   assign init_bus.soft_rst    = i_soft_rst;
   assign init_bus.stage_valid = i_init_stage_valid;
   assign init_bus.stage_in    = i_init_stage;
   assign init_bus.ack_in      = i_init_ack_slot;
   assign init_bus.byte_done   = i_init_byte_done;

   sats_init_track u_init_track (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .bus     (init_bus)
   );

   // ----------------------------------------------------------------
   // Status word and read port
   // ----------------------------------------------------------------
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[POS_TGT_SEL]          = selected_reg;
      status_word[POS_LINE_BUSY]        = line_busy_reg;
      status_word[POS_HOLD_OFF]         = hold_off;
      status_word[POS_TGT_STAGE +: 2]   = tstage_reg;
      status_word[POS_TGT_ACK]          = tgt_ack;
      status_word[POS_TGT_SUB +: 8]     = sub_addr_reg;
      status_word[POS_INIT_BUSY]        = start_reg;
      status_word[POS_INIT_STAGE +: 3]  = init_bus.stage_q;
      status_word[POS_INIT_ACK]         = init_bus.ack_q;
      status_word[POS_INIT_TALLY +: 4]  = init_bus.tally_q;
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (i_rd) begin
         unique case (i_addr)
            OFF_ACC_STATUS: rdata_reg <= status_word;
            OFF_TARGET_CFG: begin
               rdata_reg <= 32'h0000_0000;
               rdata_reg[POS_CFG_EN]        <= tgt_en_reg;
               rdata_reg[POS_CFG_ADDR +: 7] <= own_addr_reg;
            end
            OFF_INIT_CTRL: begin
               rdata_reg <= 32'h0000_0000;
               rdata_reg[POS_CTRL_START]    <= start_reg;
               rdata_reg[POS_CTRL_SIZE +: 4] <= size_reg;
            end
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_rdata        = rdata_reg;
   assign o_sda_out      = 1'b0;
   assign o_sda_oe       = sda_oe_reg;
   assign o_tgt_wr_byte  = wr_byte_reg;
   assign o_tgt_wr_valid = wr_valid_reg;
   assign o_init_start   = start_reg;
   assign o_init_size    = size_reg;
endmodule

//--- core/sats_pkg.sv
// Shared constants and types for the serial access status tracker
package sats_pkg;
   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W           = 20;
   localparam logic [19:0] OFF_ACC_STATUS   = 20'h1d118;
   localparam logic [19:0] OFF_TARGET_CFG   = 20'h1d120;
   localparam logic [19:0] OFF_INIT_CTRL    = 20'h1d124;
   // ----------------------------------------------------------------
   // Status word field positions (bit 31 is the first printed bit)
   // ----------------------------------------------------------------
   localparam int unsigned POS_TGT_SEL      = 31;
   localparam int unsigned POS_LINE_BUSY    = 30;
   localparam int unsigned POS_HOLD_OFF     = 27;
   localparam int unsigned POS_TGT_STAGE    = 25;
   localparam int unsigned POS_TGT_ACK      = 24;
   localparam int unsigned POS_TGT_SUB      = 16;
   localparam int unsigned POS_INIT_BUSY    = 15;
   localparam int unsigned POS_INIT_STAGE   = 9;
   localparam int unsigned POS_INIT_ACK     = 8;
   localparam int unsigned POS_INIT_TALLY   = 0;
   // ----------------------------------------------------------------
   // Control field positions, reset values and bus constants
   // ----------------------------------------------------------------
   localparam int unsigned POS_CFG_ADDR     = 0;
   localparam int unsigned POS_CFG_EN       = 8;
   localparam int unsigned POS_CTRL_START   = 0;
   localparam int unsigned POS_CTRL_SIZE    = 4;
   localparam logic [6:0]  RST_OWN_ADDR     = 7'h00;
   localparam logic        RST_TGT_EN       = 1'b0;
   localparam logic [3:0]  RST_SIZE         = 4'h0;
   localparam logic [6:0]  ALERT_ADDR       = 7'h0c;
   localparam logic [3:0]  ACK_BIT          = 4'h8;
   localparam logic [3:0]  LAST_DATA_BIT    = 4'h7;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TSTG_ADDR  = 2'b00,
      TSTG_SUB   = 2'b01,
      TSTG_WDATA = 2'b10,
      TSTG_RDATA = 2'b11
   } sats_tstage_t;
   typedef enum logic [2:0] {
      ISTG_START   = 3'b000,
      ISTG_ADDR    = 3'b001,
      ISTG_SUB     = 3'b010,
      ISTG_RESTART = 3'b011,
      ISTG_RDATA   = 3'b100,
      ISTG_WDATA   = 3'b101,
      ISTG_STOP    = 3'b110
   } sats_istage_t;
   typedef enum logic [2:0] {
      TS_IDLE  = 3'b000,
      TS_ADDR  = 3'b001,
      TS_SUB   = 3'b010,
      TS_WDATA = 3'b011,
      TS_RDATA = 3'b100,
      TS_WAIT  = 3'b101
   } sats_tstate_t;
endpackage

//--- core/sats_init_if.sv
// Carrier between the core and the initiator status tracker
`timescale 1ns/1ps
interface sats_init_if;
   logic         busy;
   logic         soft_rst;
   logic         stage_valid;
   logic [2:0]   stage_in;
   logic         ack_in;
   logic         byte_done;
   logic [2:0]   stage_q;
   logic         ack_q;
   logic [3:0]   tally_q;
   modport core (
      output busy, soft_rst, stage_valid, stage_in, ack_in, byte_done,
      input  stage_q, ack_q, tally_q
   );
   modport tracker (
      input  busy, soft_rst, stage_valid, stage_in, ack_in, byte_done,
      output stage_q, ack_q, tally_q
   );
endinterface

//--- core/sats_pin_sync.sv
// Three-stage synchroniser with agreement filter for bus pins
`timescale 1ns/1ps
module sats_pin_sync #(
   parameter int unsigned     WIDTH      = 2,
   parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] ff1_reg;
   logic [WIDTH-1:0] ff2_reg;
   logic [WIDTH-1:0] ff3_reg;
   logic [WIDTH-1:0] level_reg;

   // Idle bus is high, so reset to high avoids a false START
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff1_reg   <= IDLE_LEVEL;
         ff2_reg   <= IDLE_LEVEL;
         ff3_reg   <= IDLE_LEVEL;
         level_reg <= IDLE_LEVEL;
      end else begin
         ff1_reg   <= i_async;
         ff2_reg   <= ff1_reg;
         ff3_reg   <= ff2_reg;
         level_reg <= (ff2_reg & ff3_reg) | (level_reg & (ff2_reg ^ ff3_reg));
      end
   end

   assign o_level = level_reg;
endmodule

//--- core/sats_init_track.sv
// Initiator stage, acknowledge slot and byte tally tracker
`timescale 1ns/1ps
module sats_init_track import sats_pkg::*; (
   input  wire logic   i_clock,
   input  wire logic   i_rst_n,
   sats_init_if.tracker bus
);
   logic       busy_q_reg;
   logic [2:0] stage_reg;
   logic       ack_reg;
   logic [3:0] tally_reg;
   logic       start_seen;

   assign start_seen = bus.busy & ~busy_q_reg;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_q_reg <= 1'b0;
      end else begin
         busy_q_reg <= bus.busy;
      end
   end

   // Stage holds after the operation ends or aborts
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage_reg <= ISTG_START;
      end else if (bus.soft_rst) begin
         stage_reg <= ISTG_START;
      end else if (bus.busy && bus.stage_valid) begin
         stage_reg <= bus.stage_in;
      end else if (start_seen) begin
         stage_reg <= ISTG_START;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus.busy & bus.ack_in & ~bus.soft_rst;
      end
   end

   // Tally is never cleared at the end, so an abort leaves the partial count
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tally_reg <= 4'h0;
      end else if (bus.soft_rst || start_seen) begin
         tally_reg <= 4'h0;
      end else if (bus.busy && bus.byte_done && tally_reg != 4'hf) begin
         tally_reg <= tally_reg + 4'h1;
      end
   end

   assign bus.stage_q = stage_reg;
   assign bus.ack_q   = ack_reg;
   assign bus.tally_q = tally_reg;
endmodule

//--- tb/sats_assertions.sv
// Port checker for the serial access status tracker
`timescale 1ns/1ps
module sats_assertions import sats_pkg::*; (
   input wire logic              i_clock,
   input wire logic              i_rst_n,
   input wire logic              i_soft_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0]       i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic [31:0]       o_rdata,
   input wire logic              o_init_start,
   input wire logic [3:0]        o_init_size
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   sequence s_rd;
      i_rd && i_addr == OFF_ACC_STATUS;
   endsequence
   sequence s_ctl;
      i_wr && i_addr == OFF_INIT_CTRL;
   endsequence
   AST_RSVD: assert property (s_rd |=> (o_rdata & 32'h300070f0) == 32'h0)
      else $error("reserved status bits set");
   AST_BUSY: assert property (s_rd |=> o_rdata[15] == $past(o_init_start))
      else $error("busy bit differs from start bit");
   AST_SOFT: assert property (i_soft_rst ##1 s_rd |=> !o_rdata[27] && !o_rdata[15])
      else $error("soft reset left flags set");
   AST_START: assert property (s_ctl ##0 i_wdata[0] && !i_soft_rst |=> o_init_start)
      else $error("start write not taken");
   AST_SZ_HOLD: assert property (s_ctl ##0 o_init_start |=> $stable(o_init_size))
      else $error("size changed while busy");
   AST_STAGE: assert property (s_rd |=> o_rdata[11:9] != 3'h7)
      else $error("reserved initiator stage");
   AST_HOLD_OFF: assert property (s_rd |=> !o_rdata[27] || (o_rdata[30] && !o_rdata[31]))
      else $error("hold-off without busy line or while selected");
   AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 32'h0)
      else $error("read data outside read slot");
endmodule
bind sats_core sats_assertions i_sats_assertions (.*);

//--- tb/sats_tw_master.sv
// External two-wire bus master model
`timescale 1ns/1ps
module sats_tw_master (
   output logic o_scl,
   output logic o_sda
);
   // Clock stands high outside frames
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic bit_t(input logic b);
      o_sda = b;
      #31 o_scl = 1'b1;
      #62 o_scl = 1'b0;
      #32;
   endtask
   task automatic start();
      #62 o_sda = 1'b0;
      #62 o_scl = 1'b0;
      #32;
   endtask
   task automatic stop();
      o_sda = 1'b0;
      #31 o_scl = 1'b1;
      #62 o_sda = 1'b1;
      #62;
   endtask
   task automatic data_bits(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) bit_t(b[i]);
   endtask
   // Releases the line in the ninth bit so the target can acknowledge
   task automatic wr_byte(input logic [7:0] b);
      data_bits(b);
      bit_t(1'b1);
   endtask
endmodule

//--- tb/sats_core_tb.sv
// Self-checking bench for the serial access status tracker
`timescale 1ns/1ps
module sats_core_tb import sats_pkg::*;;
   typedef struct {logic [19:0] a; logic [31:0] d; logic [19:0] ra; logic [31:0] e;} sats_row_t;
   logic i_clock, i_rst_n, i_soft_rst, i_wr, i_rd, o_sda_out, o_sda_oe, o_tgt_wr_valid;
   logic i_init_stage_valid, i_init_ack_slot, i_init_byte_done, i_init_done, i_init_abort;
   logic o_init_start, m_scl, m_sda;
   logic [ADDR_W-1:0] i_addr;
   logic [31:0]       i_wdata, o_rdata;
   logic [7:0]        i_tgt_rd_byte, o_tgt_wr_byte;
   logic [2:0]        i_init_stage;
   logic [3:0]        o_init_size;
   wire               i_scl = m_scl;
   wire               i_sda = m_sda & ~o_sda_oe;
   int                error_cnt, n_tests, cyc;
   sats_row_t rows [4] = '{'{OFF_ACC_STATUS, 32'hffffffff, OFF_ACC_STATUS, 32'h0},
      '{20'h1d11c, 32'hffffffff, 20'h1d11c, 32'h0}, '{OFF_INIT_CTRL, 32'h30, OFF_ACC_STATUS,
      32'h0}, '{OFF_TARGET_CFG, 32'h150, OFF_ACC_STATUS, 32'h0}};
   sats_core i_sats_core (.*);
   sats_tw_master i_sats_tw_master (.o_scl(m_scl), .o_sda(m_sda));
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   // Cuts a hang short well past the expected run length
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic chk(input logic [19:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      i_soft_rst <= 1'b0;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 cmp(o_rdata, e);
   endtask
   task automatic ev(input logic [3:0] p, input logic [2:0] s);
      @(posedge i_clock);
      {i_init_stage_valid, i_init_byte_done, i_init_done, i_init_abort} <= p;
      i_init_stage <= s;
      @(posedge i_clock);
      {i_init_stage_valid, i_init_byte_done, i_init_done, i_init_abort} <= 4'h0;
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      {i_rst_n, i_soft_rst, i_wr, i_rd, i_init_stage_valid, i_init_ack_slot} = 6'h0;
      {i_init_byte_done, i_init_done, i_init_abort, i_init_stage} = 6'h0;
      i_addr = '0;
      i_wdata = 32'h0;
      i_tgt_rd_byte = 8'h5a;
      repeat (20) @(posedge i_clock);
      i_rst_n <= 1'b1;
      chk(OFF_ACC_STATUS, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk(rows[i].ra, rows[i].e);
      end
      wr(OFF_INIT_CTRL, 32'h31);
      chk(OFF_ACC_STATUS, 32'h8000);
      for (int s = 0; s < 7; s++) begin
         ev(4'h8, s[2:0]);
         chk(OFF_ACC_STATUS, 32'h8000 | (s << 9));
      end
      @(posedge i_clock) i_init_ack_slot <= 1'b1;
      chk(OFF_ACC_STATUS, 32'h8d00);
      @(posedge i_clock) i_init_ack_slot <= 1'b0;
      wr(OFF_INIT_CTRL, 32'h51);
      #1 cmp({28'h0, o_init_size}, 32'h3);
      ev(4'h8, 3'h5);
      repeat (3) ev(4'h4, 3'h0);
      chk(OFF_ACC_STATUS, 32'h8a03);
      ev(4'h1, 3'h0);
      chk(OFF_ACC_STATUS, 32'h0a03);
      wr(OFF_INIT_CTRL, 32'h31);
      chk(OFF_ACC_STATUS, 32'h8000);
      repeat (3) ev(4'h4, 3'h0);
      ev(4'h2, 3'h0);
      chk(OFF_ACC_STATUS, 32'h0003);
      wr(OFF_INIT_CTRL, 32'h31);
      ev(4'h8, 3'h2);
      @(posedge i_clock) i_soft_rst <= 1'b1;
      chk(OFF_ACC_STATUS, 32'h0);
      i_sats_tw_master.start();
      i_sats_tw_master.data_bits(8'ha0);
      repeat (6) @(posedge i_clock);
      chk(OFF_ACC_STATUS, 32'hc1000000);
      cmp({30'h0, o_sda_out, o_sda_oe}, 32'h1);
      i_sats_tw_master.bit_t(1'b1);
      repeat (6) @(posedge i_clock);
      chk(OFF_ACC_STATUS, 32'hc2000000);
      i_sats_tw_master.wr_byte(8'h12);
      i_sats_tw_master.wr_byte(8'h34);
      i_sats_tw_master.stop();
      repeat (6) @(posedge i_clock);
      chk(OFF_ACC_STATUS, 32'h04130000);
      cmp({24'h0, o_tgt_wr_byte}, 32'h34);
      i_sats_tw_master.start();
      i_sats_tw_master.wr_byte(8'h19);
      repeat (6) @(posedge i_clock);
      chk(OFF_ACC_STATUS, 32'hc6130000);
      cmp({30'h0, o_sda_out, o_sda_oe}, 32'h1);
      i_sats_tw_master.wr_byte(8'hff);
      repeat (6) @(posedge i_clock);
      chk(OFF_ACC_STATUS, 32'h4e130000);
      i_sats_tw_master.stop();
      i_sats_tw_master.start();
      i_sats_tw_master.wr_byte(8'h22);
      repeat (6) @(posedge i_clock);
      chk(OFF_ACC_STATUS, 32'h48130000);
      i_sats_tw_master.stop();
      repeat (6) @(posedge i_clock);
      chk(OFF_ACC_STATUS, 32'h00130000);
      test_done();
   end
endmodule
